// ---- design/uet_core.v ----
`include "uet_defines.vh"
`timescale 1ns/100ps
`default_nettype none

module uet_core (
  input wire SYS_CLK, // 50 MHz clock
  input wire RSTN, // async reset, active low
  input wire AVS_READ, // avalon read request
  input wire AVS_WRITE, // avalon write request
  input wire [5:0] AVS_ADDRESS, // byte address
  input wire [3:0] AVS_BYTEENABLE, // byte lanes
  input wire [31:0] AVS_WRITEDATA, // write data
  output reg [31:0] AVS_READDATA, // read data
  output wire AVS_WAITREQUEST, // stall of the bus request
  input wire TOK_VALID, // token received, one-cycle pulse
  input wire [1:0] TOK_PID, // token kind
  input wire [1:0] TOK_EP, // token endpoint
  input wire DAT_VALID, // data packet end, one-cycle pulse
  input wire [1:0] DAT_PID, // data pid of packet
  input wire DAT_CRC_OK, // packet free of errors
  input wire HS_ACK, // valid ack handshake, pulse
  input wire HS_TIMEOUT, // handshake wait expired, pulse
  output reg RSP_VALID, // response request, pulse
  output reg [1:0] RSP_KIND, // handshake or data
  output reg [1:0] RSP_PID, // data pid when kind is data
  output reg [1:0] RSP_EP, // endpoint of response or accept
  output reg RX_ACCEPT, // data packet taken by function, pulse
  output reg RX_SETUP // accepted packet was setup data
);

  // address decoding shared by read and write paths
  // returns 0 ctrl, 1 cfg, 2 stat, 3 unmapped
  function [1:0] addr_region;
    input [5:0] a;
    begin
      if (a == `UET_OFF_CTRL)
        addr_region = 2'h0;
      else if ({a[5:4], 4'h0} == `UET_OFF_CFG && a[1:0] == 2'h0)
        addr_region = 2'h1;
      else if ({a[5:4], 4'h0} == `UET_OFF_STAT && a[1:0] == 2'h0)
        addr_region = 2'h2;
      else
        addr_region = 2'h3;
    end
  endfunction

  // bus side state
  reg ack_q;
  reg hs_q;

  // open transaction: state, endpoint, setup and stall marks
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [1:0] ep_q;
  reg [1:0] ep_d;
  reg setup_q;
  reg setup_d;
  reg stall_q;
  reg stall_d;

  // combinational response and endpoint event strobes
  reg rsp_v;
  reg [1:0] rsp_k;
  reg [1:0] rsp_p;
  reg acc;
  reg ev_tok_setup;
  reg ev_setup;
  reg ev_tx_ack;
  reg ev_iso_tx;
  reg ev_rx;

  // per-endpoint fields gathered into flat vectors
  wire [31:0] cfg_all;
  wire [3:0] pend_all;
  wire [3:0] pstall_all;
  wire [3:0] tx_all;
  wire [3:0] rx_all;
  wire [31:0] stat_all;
  // write strobes and config views of token and current endpoint
  wire wr_en;
  wire cfg_evt;
  wire [7:0] t_cfg;
  wire [1:0] t_type;
  wire [7:0] c_cfg;
  wire [1:0] c_type;
  wire c_exp;

  // one wait cycle, then the request completes at the next edge
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_q;
  assign wr_en = AVS_WRITE & ack_q & AVS_BYTEENABLE[0];
  assign cfg_evt = wr_en && addr_region(AVS_ADDRESS) == 2'h0 &&
                   AVS_WRITEDATA[`UET_CTRL_CFGEVT];

  // bus handshake and registered read data
  always @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ack_q <= 1'b0;
      AVS_READDATA <= 32'h0;
      hs_q <= 1'b0;
    end else begin
      ack_q <= (AVS_READ | AVS_WRITE) & ~ack_q;
      // read data loads in the wait cycle, stands when waitrequest drops
      if (AVS_READ && !ack_q) begin
        case (addr_region(AVS_ADDRESS))
          2'h0: AVS_READDATA <= {31'h0, hs_q};
          2'h1: AVS_READDATA <= {24'h0, cfg_all[8*AVS_ADDRESS[3:2] +: 8]};
          2'h2: AVS_READDATA <= {24'h0, stat_all[8*AVS_ADDRESS[3:2] +: 8]};
          default: AVS_READDATA <= 32'h0;
        endcase
      end
      // high-speed mode bit of the control register
      if (wr_en && addr_region(AVS_ADDRESS) == 2'h0)
        hs_q <= AVS_WRITEDATA[`UET_CTRL_HS];
    end
  end

  // per-endpoint state
  genvar gi;
  generate
    for (gi = 0; gi < `UET_NUM_EP; gi = gi + 1) begin : ep_g
      // endpoint config, flags and sequence bits
      reg [7:0] cfg_q;
      reg pend_q;
      reg pstall_q;
      reg tx_q;
      reg rx_q;
      reg got_q;
      reg [1:0] lpid_q;
      // transaction select and register write decodes
      wire sel;
      wire wr_cfg;
      wire wr_cmd;
      assign sel = (ep_d == gi);
      assign wr_cfg = wr_en && addr_region(AVS_ADDRESS) == 2'h1 &&
                      AVS_ADDRESS[3:2] == gi;
      assign wr_cmd = wr_en && addr_region(AVS_ADDRESS) == 2'h2 &&
                      AVS_ADDRESS[3:2] == gi;
      // flat views for the responder and the status read
      assign cfg_all[8*gi +: 8] = cfg_q;
      assign pend_all[gi] = pend_q;
      assign pstall_all[gi] = pstall_q;
      assign tx_all[gi] = tx_q;
      assign rx_all[gi] = rx_q;
      assign stat_all[8*gi +: 8] = {lpid_q, got_q, cfg_q[`UET_CFG_HALT],
                                    rx_q, tx_q, pstall_q, pend_q};
      // all endpoint state starts clear
      always @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
          cfg_q <= `UET_CFG_RESET;
          pend_q <= 1'b0;
          pstall_q <= 1'b0;
          tx_q <= 1'b0;
          rx_q <= 1'b0;
          got_q <= 1'b0;
          lpid_q <= 2'h0;
        end else begin
          if (wr_cfg)
            cfg_q <= AVS_WRITEDATA[7:0];
          // a new event written in the ack cycle is kept
          if (wr_cmd && AVS_WRITEDATA[`UET_CMD_PEND])
            pend_q <= 1'b1;
          else if (sel && (ev_tx_ack || ev_iso_tx))
            pend_q <= 1'b0;
          // failed command enters protocol stall
          if (wr_cmd && AVS_WRITEDATA[`UET_CMD_STALL])
            pstall_q <= 1'b1;
          else if (sel && ev_tok_setup)
            pstall_q <= 1'b0;
          // transmit sequence bit
          if (cfg_evt)
            tx_q <= 1'b0;
          else if (sel && ev_setup)
            tx_q <= 1'b1;
          else if (sel && ev_tx_ack)
            tx_q <= ~tx_q;
          // receive sequence bit
          if (cfg_evt)
            rx_q <= 1'b0;
          else if (sel && ev_setup)
            rx_q <= 1'b1;
          else if (sel && ev_rx)
            rx_q <= ~rx_q;
          // sticky data-received flag, set beats clear
          if (sel && acc) begin
            got_q <= 1'b1;
            lpid_q <= DAT_PID;
          end else if (wr_cmd && AVS_WRITEDATA[`UET_CMD_GOTCLR]) begin
            got_q <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // config of the token endpoint and of the current endpoint
  assign t_cfg = cfg_all[8*TOK_EP +: 8];
  assign t_type = t_cfg[`UET_CFG_TYPE_LO +: 2];
  assign c_cfg = cfg_all[8*ep_q +: 8];
  assign c_type = c_cfg[`UET_CFG_TYPE_LO +: 2];
  // status stage expects data1, else the receive bit
  assign c_exp = c_cfg[`UET_CFG_STATUS] | rx_all[ep_q];

  // transaction responder
  always @* begin
    state_d = state_q;
    ep_d = ep_q;
    setup_d = setup_q;
    stall_d = stall_q;
    rsp_v = 1'b0;
    rsp_k = `UET_RSP_ACK;
    rsp_p = `UET_PID_DATA0;
    acc = 1'b0;
    ev_tok_setup = 1'b0;
    ev_setup = 1'b0;
    ev_tx_ack = 1'b0;
    ev_iso_tx = 1'b0;
    ev_rx = 1'b0;
    if (TOK_VALID) begin
      // a new token abandons any unfinished transaction
      ep_d = TOK_EP;
      state_d = `UET_S_IDLE;
      case (TOK_PID)
        `UET_TOK_IN: begin
          if (t_type == `UET_EP_ISO) begin
            // no handshake follows, no retry
            rsp_v = 1'b1;
            rsp_k = `UET_RSP_DATA;
            ev_iso_tx = 1'b1;
            if (hs_q && t_cfg[`UET_CFG_HB])
              rsp_p = t_cfg[`UET_CFG_ISOPID_LO +: 2];
            else
              rsp_p = `UET_PID_DATA0;
          end else if (t_cfg[`UET_CFG_HALT] ||
                       (t_type == `UET_EP_CTRL && pstall_all[TOK_EP])) begin
            rsp_v = 1'b1;
            rsp_k = `UET_RSP_STALL;
          end else if (!pend_all[TOK_EP]) begin
            rsp_v = 1'b1;
            rsp_k = `UET_RSP_NAK;
          end else begin
            rsp_v = 1'b1;
            rsp_k = `UET_RSP_DATA;
            rsp_p = {1'b0, t_cfg[`UET_CFG_STATUS] | tx_all[TOK_EP]};
            state_d = `UET_S_WHS;
          end
        end
        `UET_TOK_OUT: begin
          state_d = `UET_S_WDATA;
          setup_d = 1'b0;
          stall_d = t_type != `UET_EP_ISO && (t_cfg[`UET_CFG_HALT] ||
                    (t_type == `UET_EP_CTRL && pstall_all[TOK_EP]));
        end
        `UET_TOK_SETUP: begin
          if (t_type == `UET_EP_CTRL) begin
            state_d = `UET_S_WDATA;
            setup_d = 1'b1;
            stall_d = 1'b0;
            ev_tok_setup = 1'b1;
          end
        end
        default: state_d = `UET_S_IDLE;
      endcase
    end else begin
      case (state_q)
        `UET_S_WDATA: begin
          if (DAT_VALID) begin
            state_d = `UET_S_IDLE;
            // corrupted packets get no answer at all
            if (!DAT_CRC_OK) begin
              state_d = `UET_S_IDLE;
            end else if (c_type == `UET_EP_ISO) begin
              // isochronous out: no handshake, no sequence bits
              if ((hs_q && c_cfg[`UET_CFG_HB]) || !DAT_PID[1])
                acc = 1'b1;
            end else if (setup_q) begin
              acc = 1'b1;
              ev_setup = 1'b1;
              rsp_v = 1'b1;
              rsp_k = `UET_RSP_ACK;
            end else if (stall_q) begin
              rsp_v = 1'b1;
              rsp_k = `UET_RSP_STALL;
            end else if (!c_cfg[`UET_CFG_RDY]) begin
              rsp_v = 1'b1;
              rsp_k = `UET_RSP_NAK;
            end else if (DAT_PID == {1'b0, c_exp}) begin
              acc = 1'b1;
              ev_rx = !c_cfg[`UET_CFG_STATUS];
              rsp_v = 1'b1;
              rsp_k = `UET_RSP_ACK;
            end else begin
              rsp_v = 1'b1;
              rsp_k = `UET_RSP_ACK;
            end
          end
        end
        `UET_S_WHS: begin
          // silence from the host means a retry with the same bit
          if (HS_ACK) begin
            ev_tx_ack = !c_cfg[`UET_CFG_STATUS];
            ev_iso_tx = c_cfg[`UET_CFG_STATUS];
            state_d = `UET_S_IDLE;
          end else if (HS_TIMEOUT) begin
            state_d = `UET_S_IDLE;
          end
        end
        `UET_S_IDLE: state_d = `UET_S_IDLE;
        default: state_d = `UET_S_IDLE;
      endcase
    end
  end

  // transaction state and registered responses
  always @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= `UET_S_IDLE;
      ep_q <= 2'h0;
      setup_q <= 1'b0;
      stall_q <= 1'b0;
      RSP_VALID <= 1'b0;
      RSP_KIND <= `UET_RSP_ACK;
      RSP_PID <= `UET_PID_DATA0;
      RSP_EP <= 2'h0;
      RX_ACCEPT <= 1'b0;
      RX_SETUP <= 1'b0;
    end else begin
      state_q <= state_d;
      ep_q <= ep_d;
      setup_q <= setup_d;
      stall_q <= stall_d;
      RSP_VALID <= rsp_v;
      RX_ACCEPT <= acc;
      // kind and pid hold until the next response
      if (rsp_v) begin
        RSP_KIND <= rsp_k;
        RSP_PID <= rsp_p;
      end
      if (rsp_v || acc)
        RSP_EP <= ep_d;
      // setup flag follows the last accepted packet
      if (acc)
        RX_SETUP <= setup_q;
    end
  end

endmodule // uet_core

`default_nettype wire

// ---- design/uet_defines.vh ----
`ifndef UET_DEFINES_VH
`define UET_DEFINES_VH

// endpoint count and index width
`define UET_NUM_EP 4
`define UET_EPW 2

// token kinds on TOK_PID
`define UET_TOK_OUT 2'h0
`define UET_TOK_IN 2'h1
`define UET_TOK_SETUP 2'h2

// data pid codes on DAT_PID and RSP_PID
`define UET_PID_DATA0 2'h0
`define UET_PID_DATA1 2'h1
`define UET_PID_DATA2 2'h2
`define UET_PID_MDATA 2'h3

// response kinds on RSP_KIND
`define UET_RSP_ACK 2'h0
`define UET_RSP_NAK 2'h1
`define UET_RSP_STALL 2'h2
`define UET_RSP_DATA 2'h3

// endpoint transfer types
`define UET_EP_CTRL 2'h0
`define UET_EP_BULK 2'h1
`define UET_EP_INTR 2'h2
`define UET_EP_ISO 2'h3

// register byte offsets
`define UET_OFF_CTRL 6'h00
`define UET_OFF_CFG 6'h10
`define UET_OFF_STAT 6'h20

// control register fields
`define UET_CTRL_HS 0
`define UET_CTRL_CFGEVT 1

// endpoint config fields
`define UET_CFG_TYPE_LO 0
`define UET_CFG_HB 2
`define UET_CFG_HALT 3
`define UET_CFG_RDY 4
`define UET_CFG_STATUS 5
`define UET_CFG_ISOPID_LO 6
`define UET_CFG_RESET 8'h00

// endpoint command (write) fields
`define UET_CMD_PEND 0
`define UET_CMD_STALL 1
`define UET_CMD_GOTCLR 2

// endpoint status (read) fields
`define UET_ST_PEND 0
`define UET_ST_PSTALL 1
`define UET_ST_TXSEQ 2
`define UET_ST_RXSEQ 3
`define UET_ST_HALT 4
`define UET_ST_GOT 5
`define UET_ST_LPID_LO 6

// transaction states
`define UET_S_IDLE 2'h0
`define UET_S_WDATA 2'h1
`define UET_S_WHS 2'h2

`endif

// ---- tb/uet_core_assertions.sv ----
`include "uet_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module uet_core_chk (
  input wire logic SYS_CLK, // clock
  input wire logic RSTN, // reset, active low
  input wire logic AVS_READ, // bus read
  input wire logic AVS_WRITE, // bus write
  input wire logic AVS_WAITREQUEST, // bus stall
  input wire logic TOK_VALID, // token pulse
  input wire logic [1:0] TOK_PID, // token kind
  input wire logic DAT_VALID, // data pulse
  input wire logic DAT_CRC_OK, // data good
  input wire logic HS_ACK, // host ack
  input wire logic RSP_VALID, // response pulse
  input wire logic [1:0] RSP_KIND, // response kind
  input wire logic RX_ACCEPT, // data taken
  input wire logic RX_SETUP // setup data flag
);
  // one clock domain, checks off in reset
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  // bus request waits exactly one cycle
  chk_bus_one_wait: assert property (
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("bus wait wrong");
  // every in token is answered next cycle, never by ack
  chk_in_answered: assert property (
    TOK_VALID && TOK_PID == `UET_TOK_IN |=> RSP_VALID &&
    RSP_KIND != `UET_RSP_ACK) else $error("in token unanswered");
  // out and setup tokens wait for their data
  chk_out_waits: assert property (
    TOK_VALID && TOK_PID != `UET_TOK_IN |=> !RSP_VALID)
    else $error("early answer to out token");
  // corrupted data leaves no trace
  chk_bad_silent: assert property (
    DAT_VALID && !DAT_CRC_OK && !TOK_VALID |=> !RSP_VALID && !RX_ACCEPT)
    else $error("answer to corrupted data");
  // accepts come only from good data
  chk_accept_good: assert property (
    RX_ACCEPT |-> $past(DAT_VALID) && $past(DAT_CRC_OK))
    else $error("accept without good data");
  // an answered accept is always an ack
  chk_accept_ack: assert property (
    RX_ACCEPT && RSP_VALID |-> RSP_KIND == `UET_RSP_ACK)
    else $error("accept without ack");
  // the device never answers on its own
  chk_rsp_cause: assert property (
    RSP_VALID |-> $past(TOK_VALID) || $past(DAT_VALID))
    else $error("response without cause");
  // an ack from the host draws no response
  chk_ack_quiet: assert property (
    HS_ACK && !TOK_VALID |=> !RSP_VALID) else $error("answer to ack");
  // setup flag moves only with an accept
  chk_setup_flag: assert property (
    $changed(RX_SETUP) |-> RX_ACCEPT) else $error("setup flag moved");
  // main scenarios reached
  cover property (RSP_VALID && RSP_KIND == `UET_RSP_STALL);
  cover property (RX_ACCEPT && RX_SETUP);
  cover property (RSP_VALID && RSP_KIND == `UET_RSP_DATA ##[1:8] HS_ACK);
endmodule // uet_core_chk
bind uet_core uet_core_chk u_chk (.*);
`default_nettype wire

// ---- tb/uet_host_model.sv ----
`include "uet_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module uet_host_model (
  input wire logic sys_clk, // clock
  output logic tok_valid, // token pulse
  output logic [1:0] tok_pid, // token kind
  output logic [1:0] tok_ep, // token endpoint
  output logic dat_valid, // data pulse
  output logic [1:0] dat_pid, // data pid
  output logic dat_crc_ok, // data good
  output logic hs_ack, // ack pulse
  output logic hs_timeout, // handshake wait over
  input wire logic rsp_valid, // response pulse
  input wire logic [1:0] rsp_kind, // response kind
  input wire logic [1:0] rsp_pid, // response pid
  input wire logic rx_accept // data taken
);
  logic got_q, acc_q;
  logic [1:0] kind_q, pid_q;
  // idle lines at time zero
  initial begin
    {tok_valid, dat_valid, hs_ack, hs_timeout} = 4'h0;
    {tok_pid, tok_ep, dat_pid, dat_crc_ok} = 7'h0;
  end
  // token for one cycle, fields scrambled after
  task tok(input logic [1:0] p, input logic [1:0] e);
    @(posedge sys_clk);
    {tok_valid, tok_pid, tok_ep} <= {1'h1, p, e};
    @(posedge sys_clk);
    {tok_valid, tok_pid, tok_ep} <= {1'h0, ~p, ~e};
  endtask
  // data packet of any of the four pids
  task dat(input logic [1:0] p, input logic ok);
    @(posedge sys_clk);
    {dat_valid, dat_pid, dat_crc_ok} <= {1'h1, p, ok};
    @(posedge sys_clk);
    {dat_valid, dat_pid, dat_crc_ok} <= {1'h0, ~p, ~ok};
  endtask
  // ack pulse when ack is set, else silence ending in a timeout pulse
  task hs(input logic ack);
    @(posedge sys_clk);
    {hs_ack, hs_timeout} <= {ack, !ack};
    @(posedge sys_clk);
    {hs_ack, hs_timeout} <= 2'h0;
  endtask
  // watch four edges for the answer
  task rsp;
    {got_q, acc_q, kind_q, pid_q} = 6'h0;
    repeat (4) begin
      @(posedge sys_clk);
      acc_q = acc_q | rx_accept;
      if (rsp_valid && !got_q) begin
        {got_q, kind_q} = {1'h1, rsp_kind};
        pid_q = (rsp_kind == `UET_RSP_DATA) ? rsp_pid : 2'h0;
      end
    end
  endtask
endmodule // uet_host_model
`default_nettype wire

// ---- tb/tb.sv ----
`include "uet_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic SYS_CLK, RSTN, AVS_READ, AVS_WRITE;
  logic [5:0] AVS_ADDRESS;
  logic [3:0] AVS_BYTEENABLE;
  logic [31:0] AVS_WRITEDATA, v;
  wire [31:0] AVS_READDATA;
  wire AVS_WAITREQUEST, RSP_VALID, RX_ACCEPT, RX_SETUP, TOK_VALID;
  wire DAT_VALID, DAT_CRC_OK, HS_ACK, HS_TIMEOUT;
  wire [1:0] TOK_PID, TOK_EP, DAT_PID, RSP_KIND, RSP_PID, RSP_EP;
  int fails = 0, total_checks = 0, cyc = 0;
  // expected {accept, answered, kind, pid}
  localparam logic [5:0] r_nak = 6'h14, r_stall = 6'h18, r_data = 6'h1c;
  localparam logic [5:0] r_acc = 6'h30, r_ack = 6'h10, r_iso = 6'h20;
  uet_core DUT (.*);
  uet_host_model host (.sys_clk(SYS_CLK), .tok_valid(TOK_VALID),
    .tok_pid(TOK_PID), .tok_ep(TOK_EP), .dat_valid(DAT_VALID),
    .dat_pid(DAT_PID), .dat_crc_ok(DAT_CRC_OK), .hs_ack(HS_ACK),
    .hs_timeout(HS_TIMEOUT), .rsp_valid(RSP_VALID), .rsp_kind(RSP_KIND),
    .rsp_pid(RSP_PID), .rx_accept(RX_ACCEPT));
  // clock and hang guard
  always #10 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      end_of_test;
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks = total_checks + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("unexpected at %0t got %h want %h", $time, g, e);
    end
  endtask
  // avalon write, held until waitrequest drops
  task wr(input logic [5:0] a, input logic [7:0] d, input logic [3:0] be);
    @(posedge SYS_CLK);
    {AVS_WRITE, AVS_ADDRESS, AVS_WRITEDATA} <= {1'h1, a, 24'h0, d};
    AVS_BYTEENABLE <= be;
    do @(posedge SYS_CLK); while (AVS_WAITREQUEST !== 1'h0);
    AVS_WRITE <= 1'h0;
  endtask
  // avalon read and compare
  task rchk(input logic [5:0] a, input logic [31:0] e);
    @(posedge SYS_CLK);
    {AVS_READ, AVS_ADDRESS} <= {1'h1, a};
    do @(posedge SYS_CLK); while (AVS_WAITREQUEST !== 1'h0);
    v = AVS_READDATA;
    AVS_READ <= 1'h0;
    chk(v, e);
  endtask
  // one transaction from the host, answer compared
  task txn(input logic [1:0] t, e, p, input logic ok, input logic [5:0] x);
    host.tok(t, e);
    if (t != `UET_TOK_IN) host.dat(p, ok);
    host.rsp;
    chk(32'({host.acc_q, host.got_q, host.kind_q, host.pid_q}),
      32'(x));
    if (host.got_q) chk(32'(RSP_EP), 32'(e));
  endtask
  task do_reset;
    RSTN <= 1'h0;
    repeat (12) @(posedge SYS_CLK);
    RSTN <= 1'h1;
  endtask
  // all endpoint state and config cleared; unmapped space reads zero
  task s_reset;
    for (int e = 0; e < 4; e++) begin
      rchk(6'h20 + 6'(4 * e), 32'h0);
      rchk(6'h10 + 6'(4 * e), 32'h0);
    end
    wr(6'h3c, 8'hff, 4'hf);
    rchk(6'h3c, 32'h0);
  endtask
  // interrupt endpoint: nak, data, retry, halt, configuration event
  task s_intr;
    wr(6'h14, 8'h02, 4'hf);
    txn(`UET_TOK_IN, 2'h1, 2'h0, 1'h1, r_nak);
    wr(6'h24, 8'h01, 4'h0);
    txn(`UET_TOK_IN, 2'h1, 2'h0, 1'h1, r_nak);
    wr(6'h24, 8'h01, 4'hf);
    txn(`UET_TOK_IN, 2'h1, 2'h0, 1'h1, r_data);
    host.hs(1'h1);
    rchk(6'h24, 32'h04);
    wr(6'h24, 8'h01, 4'hf);
    txn(`UET_TOK_IN, 2'h1, 2'h0, 1'h1, r_data | 6'h1);
    host.hs(1'h0);
    txn(`UET_TOK_IN, 2'h1, 2'h0, 1'h1, r_data | 6'h1);
    host.hs(1'h1);
    rchk(6'h24, 32'h00);
    wr(6'h24, 8'h01, 4'hf);
    txn(`UET_TOK_IN, 2'h1, 2'h0, 1'h1, r_data);
    host.hs(1'h1);
    wr(6'h00, 8'h02, 4'hf);
    rchk(6'h24, 32'h00);
    wr(6'h14, 8'h0a, 4'hf);
    txn(`UET_TOK_IN, 2'h1, 2'h0, 1'h1, r_stall);
    wr(6'h14, 8'h02, 4'hf);
    txn(`UET_TOK_IN, 2'h1, 2'h0, 1'h1, r_nak);
  endtask
  // control pipe: setup, protocol stall, status stage
  task s_ctrl;
    txn(`UET_TOK_SETUP, 2'h0, 2'h0, 1'h1, r_acc);
    chk(32'(RX_SETUP), 32'h1);
    rchk(6'h20, 32'h2c);
    wr(6'h20, 8'h02, 4'hf);
    txn(`UET_TOK_IN, 2'h0, 2'h0, 1'h1, r_stall);
    txn(`UET_TOK_OUT, 2'h0, 2'h1, 1'h1, r_stall);
    rchk(6'h20, 32'h2e);
    txn(`UET_TOK_SETUP, 2'h0, 2'h0, 1'h1, r_acc);
    wr(6'h10, 8'h20, 4'hf);
    wr(6'h20, 8'h01, 4'hf);
    txn(`UET_TOK_IN, 2'h0, 2'h0, 1'h1, r_data | 6'h1);
    host.hs(1'h1);
    rchk(6'h20, 32'h2c);
  endtask
  // bulk out: accept, duplicate, corrupt, busy, halted
  task s_out;
    wr(6'h18, 8'h11, 4'hf);
    txn(`UET_TOK_OUT, 2'h2, 2'h0, 1'h1, r_acc);
    chk(32'(RX_SETUP), 32'h0);
    txn(`UET_TOK_OUT, 2'h2, 2'h0, 1'h1, r_ack);
    txn(`UET_TOK_OUT, 2'h2, 2'h1, 1'h0, 6'h0);
    rchk(6'h28, 32'h28);
    wr(6'h18, 8'h01, 4'hf);
    txn(`UET_TOK_OUT, 2'h2, 2'h1, 1'h1, r_nak);
    rchk(6'h28, 32'h28);
    wr(6'h18, 8'h19, 4'hf);
    txn(`UET_TOK_OUT, 2'h2, 2'h1, 1'h1, r_stall);
  endtask
  // isochronous at full and high speed
  task s_iso;
    wr(6'h1c, 8'h13, 4'hf);
    txn(`UET_TOK_OUT, 2'h3, 2'h1, 1'h1, r_iso);
    txn(`UET_TOK_OUT, 2'h3, 2'h1, 1'h1, r_iso);
    txn(`UET_TOK_OUT, 2'h3, 2'h0, 1'h1, r_iso);
    txn(`UET_TOK_OUT, 2'h3, 2'h2, 1'h1, 6'h0);
    txn(`UET_TOK_IN, 2'h3, 2'h0, 1'h1, r_data);
    txn(`UET_TOK_IN, 2'h3, 2'h0, 1'h1, r_data);
    wr(6'h00, 8'h01, 4'hf);
    rchk(6'h00, 32'h1);
    txn(`UET_TOK_IN, 2'h3, 2'h0, 1'h1, r_data);
    wr(6'h1c, 8'h97, 4'hf);
    txn(`UET_TOK_IN, 2'h3, 2'h0, 1'h1, r_data | 6'h2);
    txn(`UET_TOK_OUT, 2'h3, 2'h3, 1'h1, r_iso);
    rchk(6'h2c, 32'he0);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // main sequence, with a second reset after the last scenario
  initial begin
    {SYS_CLK, RSTN, AVS_READ, AVS_WRITE, AVS_ADDRESS} = 10'h0;
    {AVS_BYTEENABLE, AVS_WRITEDATA} = 36'h0;
    do_reset;
    s_reset;
    s_intr;
    s_ctrl;
    s_out;
    s_iso;
    do_reset;
    s_reset;
    end_of_test;
  end
endmodule // tb
`default_nettype wire
